//--- src/dcsd_top.v
// Top of the dot clock select and divider block.
`include "dcsd_consts.vh"
`default_nettype none
module dcsd_top (
  // Clock and reset.
  input wire CLK,
  input wire RESET_N,
  // Clock inputs from pins.
  input wire CLOCK_INPUT_ZERO,
  input wire CLOCK_INPUT_ONE,
  input wire CLOCK_INPUT_TWO,
  input wire DUAL_MODE_CLOCK_INPUT_P,
  input wire DUAL_MODE_CLOCK_INPUT_N,
  // Host register port.
  input wire [3:0] REGISTER_SELECT,
  input wire WR_N,
  input wire RD_N,
  input wire [7:0] DATA_IN,
  output reg [7:0] DATA_OUT,
  output reg DATA_OE,
  // Generated clocks.
  output reg PIXEL_DOT_CLOCK,
  output reg SHIFT_CLOCK_OUT,
  output reg VIDEO_CLOCK_OUT,
  output reg CLOCKS_STABLE
);
  // ===========================================================
  // Pin synchronisers
  wire c0_s, c1_s, c2_s, dp_s, dn_s, wr_s, rd_s;
  dcsd_sync2 u_s0 (.CLK(CLK), .RESET_N(RESET_N), .d(CLOCK_INPUT_ZERO), .q(c0_s));
  dcsd_sync2 u_s1 (.CLK(CLK), .RESET_N(RESET_N), .d(CLOCK_INPUT_ONE), .q(c1_s));
  dcsd_sync2 u_s2 (.CLK(CLK), .RESET_N(RESET_N), .d(CLOCK_INPUT_TWO), .q(c2_s));
  dcsd_sync2 u_sp (.CLK(CLK), .RESET_N(RESET_N), .d(DUAL_MODE_CLOCK_INPUT_P), .q(dp_s));
  dcsd_sync2 u_sn (.CLK(CLK), .RESET_N(RESET_N), .d(DUAL_MODE_CLOCK_INPUT_N), .q(dn_s));
  // Strobes are active low; idle high after reset is emulated by inverting.
  dcsd_sync2 u_sw (.CLK(CLK), .RESET_N(RESET_N), .d(~WR_N), .q(wr_s));
  dcsd_sync2 u_sr (.CLK(CLK), .RESET_N(RESET_N), .d(~RD_N), .q(rd_s));
  // Select lines and write data pass two flops as well, so they line up with the strobes.
  reg [3:0] sel_m_ff;
  reg [3:0] sel_ff;
  reg [7:0] din_m_ff;
  reg [7:0] din_ff;
  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      sel_m_ff <= 4'h0;
      sel_ff <= 4'h0;
      din_m_ff <= 8'h00;
      din_ff <= 8'h00;
    end
    else
    begin
      sel_m_ff <= REGISTER_SELECT;
      sel_ff <= sel_m_ff;
      din_m_ff <= DATA_IN;
      din_ff <= din_m_ff;
    end
  end
  // ===========================================================
  // Register port
  reg [7:0] in_sel_ff;
  reg [7:0] out_sel_ff;
  reg wr_d_ff;
  reg [1:0] settle_ff;
  wire wr_rise;
  assign wr_rise = wr_s & ~wr_d_ff;
  // Writes land on the synchronised strobe edge; full byte kept.
  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      in_sel_ff <= `DCSD_IN_RESET;
      out_sel_ff <= `DCSD_OUT_RESET;
      wr_d_ff <= 1'b0;
    end
    else
    begin
      wr_d_ff <= wr_s;
      if (wr_rise)
      begin
        // Register select decode.
        if (sel_ff == `DCSD_SEL_IN_CLK)
          in_sel_ff <= din_ff;
        else if (sel_ff == `DCSD_SEL_OUT_CLK)
          out_sel_ff <= din_ff;
      end
    end
  end
  // Read data; other select codes belong elsewhere and read zero.
  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
    end
    else
    begin
      DATA_OE <= rd_s;
      if (sel_ff == `DCSD_SEL_IN_CLK)
        DATA_OUT <= in_sel_ff;
      else if (sel_ff == `DCSD_SEL_OUT_CLK)
        DATA_OUT <= out_sel_ff;
      else
        DATA_OUT <= 8'h00;
    end
  end
  // ===========================================================
  // Source selection
  reg src_lvl;
  // Only the low nibble decodes; unknown codes give a quiet low.
  always @*
  begin
    case (in_sel_ff[3:0])
      `DCSD_SRC_ZERO: src_lvl = c0_s;
      `DCSD_SRC_ONE: src_lvl = c1_s;
      `DCSD_SRC_TWO: src_lvl = c2_s;
      `DCSD_SRC_LEG_A: src_lvl = dp_s;
      `DCSD_SRC_LEG_B: src_lvl = dn_s;
      `DCSD_SRC_DIFF: src_lvl = dp_s & ~dn_s;
      default: src_lvl = 1'b0;
    endcase
  end
  reg src_d_ff;
  wire dot_edge;
  assign dot_edge = src_lvl & ~src_d_ff;
  // ===========================================================
  // Shared counter
  wire [4:0] count;
  dcsd_divider u_div (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .dot_edge(dot_edge),
    .out_sel(out_sel_ff),
    .count_ff(count)
  );
  // Divided level for a code: code 0 follows the dot clock, else a counter bit.
  function tap;
    input [2:0] code;
    input [4:0] cnt;
    input dot;
    begin
      case (code)
        3'h0: tap = dot;
        3'h1: tap = cnt[0];
        3'h2: tap = cnt[1];
        3'h3: tap = cnt[2];
        3'h4: tap = cnt[3];
        default: tap = cnt[4];
      endcase
    end
  endfunction
  wire vid_park, shf_park;
  assign vid_park = out_sel_ff[5] & out_sel_ff[4];
  assign shf_park = out_sel_ff[2] & out_sel_ff[1];
  // ===========================================================
  // Output registers
  // Both taps share one counter so enabled edges line up.
  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      src_d_ff <= 1'b0;
      PIXEL_DOT_CLOCK <= 1'b0;
      VIDEO_CLOCK_OUT <= 1'b1;
      SHIFT_CLOCK_OUT <= 1'b0;
    end
    else
    begin
      src_d_ff <= src_lvl;
      PIXEL_DOT_CLOCK <= src_lvl;
      if (vid_park)
        VIDEO_CLOCK_OUT <= 1'b1;
      else
        // Divide by one uses the delayed level so it moves on the same edge as counter taps.
        VIDEO_CLOCK_OUT <= tap(out_sel_ff[5:3], count, src_d_ff);
      if (shf_park)
        SHIFT_CLOCK_OUT <= 1'b0;
      else
        SHIFT_CLOCK_OUT <= tap(out_sel_ff[2:0], count, src_d_ff);
    end
  end
  // ===========================================================
  // Settling indicator
  // Clocks are flagged unstable for the settle time after any selection write.
  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      settle_ff <= 2'h0;
      CLOCKS_STABLE <= 1'b0;
    end
    else if (wr_rise && (sel_ff == `DCSD_SEL_IN_CLK ||
                         sel_ff == `DCSD_SEL_OUT_CLK))
    begin
      settle_ff <= 2'h0;
      CLOCKS_STABLE <= 1'b0;
    end
    else if (settle_ff != `DCSD_SETTLE_CYC)
    begin
      settle_ff <= settle_ff + 2'h1;
      CLOCKS_STABLE <= 1'b0;
    end
    else
      CLOCKS_STABLE <= 1'b1;
  end
endmodule
`default_nettype wire

//--- src/dcsd_consts.vh
// Constants for the dot clock select and divider block.
// Behaviour
// - Input clock zero is the source after reset.
// - Codes 0, 1, 2 pick single-ended inputs.
// - Codes 3 and 4 pick one dual-mode leg.
// - Code 8 picks the differential dual-mode pair.
// - Input select bits 7 to 4 are ignored.
// - Selected input passes undivided as dot clock.
// - Bits 5:3 divide video clock by 1 to 32.
// - Video code 11x parks output high, default.
// - Bits 2:0 divide shift clock by 1 to 32.
// - Shift code 11x parks output low, default.
// - Register value is video code times eight plus shift.
// - Output select bits 7 and 6 are ignored.
// - New clocks need 30 ns to settle.
// - One shared counter drives both outputs.
// - Enabled video clock stays in phase with shift.
// - Bits 5,4,2,1 all one clears the counter.
// - Every reset parks both clocks, clears counter.
`ifndef DCSD_CONSTS_VH
`define DCSD_CONSTS_VH
// ===========================================================
// Register select codes
`define DCSD_SEL_IN_CLK 4'h9
`define DCSD_SEL_OUT_CLK 4'ha
// ===========================================================
// Reset values and field positions
`define DCSD_IN_RESET 8'h00
`define DCSD_OUT_RESET 8'h36
`define DCSD_VID_MSB 5
`define DCSD_VID_LSB 3
`define DCSD_SHF_MSB 2
`define DCSD_SHF_LSB 0
// ===========================================================
// Input source codes
`define DCSD_SRC_ZERO 4'h0
`define DCSD_SRC_ONE 4'h1
`define DCSD_SRC_TWO 4'h2
`define DCSD_SRC_LEG_A 4'h3
`define DCSD_SRC_LEG_B 4'h4
`define DCSD_SRC_DIFF 4'h8
// ===========================================================
// Settling time
`define DCSD_SETTLE_NS 30
`define DCSD_CLK_MHZ 50
`define DCSD_SETTLE_CYC ((`DCSD_SETTLE_NS * `DCSD_CLK_MHZ + 999) / 1000)
`endif

//--- src/dcsd_sync2.v
// Two flip-flop synchroniser for a pin level.
`default_nettype none
module dcsd_sync2 (
  input wire CLK,
  input wire RESET_N,
  input wire d,
  output reg q
);
  reg meta_ff;
  // First stage feeds only the second stage.
  always @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

//--- src/dcsd_divider.v
// Shared dot clock counter for the shift and video taps.
`default_nettype none
module dcsd_divider (
  input wire CLK,
  input wire RESET_N,
  input wire dot_edge,
  input wire [7:0] out_sel,
  output reg [4:0] count_ff
);
  wire park_all;
  // All four park bits set hold the counter at zero for phase alignment.
  assign park_all = out_sel[5] & out_sel[4] & out_sel[2] & out_sel[1];
  // One counter advances on each dot clock rising edge.
  always @(posedge CLK)
  begin
    if (!RESET_N)
      count_ff <= 5'h00;
    else if (park_all)
      count_ff <= 5'h00;
    else if (dot_edge)
      count_ff <= count_ff + 5'h01;
  end
endmodule
`default_nettype wire

//--- tb/dcsd_src_model.sv
// Board clock sources feeding the five clock pins.
`default_nettype none
// ======
// Source model
module dcsd_src_model (
  // Clock and stop control.
  input wire logic clk,
  input wire logic run,
  // Pin levels; the top bit is the inverted leg of the pair.
  output logic [4:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  int t = 0;
  // Sources freeze while the output selection register is written.
  always @(posedge clk)
  begin
    if (run)
      t <= t + 1;
  end
  // Half periods of 4, 5, 6 and 7 cycles keep each input distinguishable.
  assign pins = {t / 7 % 2 == 0, t / 7 % 2 == 1, t / 6 % 2 == 1, t / 5 % 2 == 1, t / 4 % 2 == 1};
endmodule
`default_nettype wire

//--- tb/dcsd_monitor.sv
// Port checker for the dot clock select and divider top.
`default_nettype none
// ======
// Checker
module dcsd_monitor (
  // Clock, reset and host port.
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic [3:0] REGISTER_SELECT,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE,
  // Generated clocks.
  input wire logic PIXEL_DOT_CLOCK,
  input wire logic SHIFT_CLOCK_OUT,
  input wire logic VIDEO_CLOCK_OUT,
  input wire logic CLOCKS_STABLE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // The reset check alone must run while reset is low.
  property p_rst;
    disable iff (1'b0) !RESET_N |=> VIDEO_CLOCK_OUT && !SHIFT_CLOCK_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("clocks not parked");
  property p_oe_on; !RD_N [*4] |=> DATA_OE; endproperty
  a_oe_on: assert property (p_oe_on) else $error("read data late");
  property p_oe_off; RD_N [*5] |=> !DATA_OE; endproperty
  a_oe_off: assert property (p_oe_off) else $error("read drive stuck");
  property p_unmap; !REGISTER_SELECT[3] [*4] |-> DATA_OUT == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("stray read data");
  property p_drop;
    $fell(WR_N) && (REGISTER_SELECT == 4'h9 || REGISTER_SELECT == 4'ha) |-> ##[1:6] !CLOCKS_STABLE;
  endproperty
  a_drop: assert property (p_drop) else $error("settle flag kept");
  property p_settle; $rose(CLOCKS_STABLE) |-> !$past(CLOCKS_STABLE, 2); endproperty
  a_settle: assert property (p_settle) else $error("settle too short");
  property p_quiet; (!PIXEL_DOT_CLOCK && WR_N) [*8] |-> $stable({SHIFT_CLOCK_OUT, VIDEO_CLOCK_OUT}); endproperty
  a_quiet: assert property (p_quiet) else $error("clock moved without dot");
  property p_hold; (WR_N && $stable(REGISTER_SELECT)) [*6] |-> $stable(DATA_OUT); endproperty
  a_hold: assert property (p_hold) else $error("register changed");
  c_wr: cover property ($fell(WR_N));
  c_rd: cover property ($rose(DATA_OE));
  c_both: cover property (SHIFT_CLOCK_OUT && VIDEO_CLOCK_OUT);
endmodule
bind dcsd_top dcsd_monitor i_dcsd_monitor (.CLK, .RESET_N, .WR_N, .RD_N, .REGISTER_SELECT,
  .DATA_OUT, .DATA_OE, .PIXEL_DOT_CLOCK, .SHIFT_CLOCK_OUT, .VIDEO_CLOCK_OUT, .CLOCKS_STABLE);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the dot clock select and divider.
`default_nettype none
// ======
// Bench top
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, RESET_N = 1'b0, WR_N = 1'b1, RD_N = 1'b1, run = 1'b1;
  logic [3:0] REGISTER_SELECT = 4'h0;
  logic [7:0] DATA_IN = 8'h00;
  logic [2:0] pv;
  wire logic [7:0] DATA_OUT;
  wire logic DATA_OE, PIXEL_DOT_CLOCK, SHIFT_CLOCK_OUT, VIDEO_CLOCK_OUT, CLOCKS_STABLE;
  wire logic [4:0] pins;
  int n_fail = 0, check_count = 0, nd, ns, nv, nx;
  logic [7:0] sc [7] = '{8'hf0, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h05};
  int se [7] = '{105, 84, 70, 60, 60, 60, 0};
  logic [7:0] oc [7] = '{8'hc0, 8'h09, 8'h0a, 8'h1b, 8'h24, 8'h2d, 8'h36};
  dcsd_src_model i_dcsd_src_model (.clk(CLK), .run, .pins);
  dcsd_top i_dcsd_top (.CLK, .RESET_N, .CLOCK_INPUT_ZERO(pins[0]), .CLOCK_INPUT_ONE(pins[1]),
    .CLOCK_INPUT_TWO(pins[2]), .DUAL_MODE_CLOCK_INPUT_P(pins[3]),
    .DUAL_MODE_CLOCK_INPUT_N(pins[4]), .REGISTER_SELECT, .WR_N, .RD_N, .DATA_IN, .DATA_OUT,
    .DATA_OE, .PIXEL_DOT_CLOCK, .SHIFT_CLOCK_OUT, .VIDEO_CLOCK_OUT, .CLOCKS_STABLE);
  // Free-running 50 MHz clock.
  initial forever #10 CLK = ~CLK;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Edge counts may be off by one at the window ends.
  task automatic near(input int s, input int e);
    chk(16'((s - e) * (s - e) <= 1 ? e : s), 16'(e));
  endtask
  task automatic finish_test;
    $display("checks=%0d failures=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wt(input bit oe);
    int j;
    for (j = 0; j < 20 && (oe ? DATA_OE : CLOCKS_STABLE && j > 3) !== 1'b1; j++)
      @(posedge CLK);
    if (j == 20)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    REGISTER_SELECT <= a;
    DATA_IN <= d;
    WR_N <= 1'b0;
    repeat (3) @(posedge CLK);
    WR_N <= 1'b1;
    wt(1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    REGISTER_SELECT <= a;
    RD_N <= 1'b0;
    wt(1'b1);
    chk(16'(DATA_OUT), 16'(e));
    RD_N <= 1'b1;
    repeat (5) @(posedge CLK);
  endtask
  // Counts rising edges, and shift toggles that no video toggle matches.
  task automatic cnt(input int w);
    {nd, ns, nv, nx} = '0;
    pv = {PIXEL_DOT_CLOCK, SHIFT_CLOCK_OUT, VIDEO_CLOCK_OUT};
    repeat (w)
    begin
      @(negedge CLK);
      nd += int'(PIXEL_DOT_CLOCK & !pv[2]);
      ns += int'(SHIFT_CLOCK_OUT & !pv[1]);
      nv += int'(VIDEO_CLOCK_OUT & !pv[0]);
      nx += int'(SHIFT_CLOCK_OUT != pv[1] && VIDEO_CLOCK_OUT == pv[0]);
      pv = {PIXEL_DOT_CLOCK, SHIFT_CLOCK_OUT, VIDEO_CLOCK_OUT};
    end
  endtask
  task automatic t_reset;
    chk(16'(VIDEO_CLOCK_OUT), 16'h0001);
    chk(16'(SHIFT_CLOCK_OUT), 16'h0000);
    rd(4'h9, 8'h00);
    rd(4'ha, 8'h36);
    rd(4'h0, 8'h00);
  endtask
  // Reset in mid-run must restore both selection registers.
  task automatic t_rerst;
    wr(4'ha, 8'h09);
    RESET_N <= 1'b0;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(4'ha, 8'h36);
    rd(4'h9, 8'h00);
  endtask
  task automatic t_src;
    for (int k = 0; k < 7; k++)
    begin
      wr(4'h9, sc[k]);
      rd(4'h9, sc[k]);
      cnt(840);
      near(nd, se[k]);
    end
    wr(4'h9, 8'h00);
  endtask
  // A parked code gives no edges; otherwise 128 edges per window, halved for each step of the code.
  function automatic int rate(input logic [2:0] c);
    return c[2:1] == 2'b11 ? 0 : 128 >> c;
  endfunction
  task automatic t_div;
    for (int k = 0; k < 7; k++)
    begin
      run <= 1'b0;
      wr(4'ha, oc[k]);
      run <= 1'b1;
      cnt(1024);
      near(ns, rate(oc[k][2:0]));
      near(nv, rate(oc[k][5:3]));
      chk(16'(nx), 16'h0000);
    end
    chk(16'(VIDEO_CLOCK_OUT), 16'h0001);
  endtask
  // Reset for three cycles, then run every scenario.
  initial
  begin
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    t_reset();
    t_src();
    t_div();
    t_rerst();
    finish_test();
  end
endmodule
`default_nettype wire
